// ---- src/txcf_regs.sv ----
`include "txcf_defs.svh"
`default_nettype none
module txcf_regs (
  // clock, reset, enable
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        clkEn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // transmit engine status
  input  wire logic        txStatusFull,
  input  wire logic        txFrameActive,
  // receive data reads by the host
  input  wire logic        rxDataRead,
  input  wire logic        rxDataLast,
  // transmit engine control and receive padding
  output logic             txRun,
  output logic             txEnabled,
  output logic             txStatusFlush,
  output logic             txDataFlush,
  output logic             rxPadding,
  // fifo partition
  output logic [3:0]       txAllocKb,
  output logic [14:0]      txDataBytes,
  output logic [14:0]      rxBytes,
  output logic             mustSetOne,
  // interrupt
  output logic             irq
);
  txcf_ctl_if ctl ();

  txcf_tx_seq u_seq (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .ctl     (ctl)
  );

  // bus decode
  logic accessEnd;
  logic wrEnd;
  logic selRxCfg;
  logic selTxCtl;
  logic selHwSet;
  logic selIntSts;
  logic selIntMsk;
  logic mapped;

  assign accessEnd = psel && penable && pready;
  assign wrEnd     = accessEnd && pwrite;
  assign selRxCfg  = (paddr == `TXCF_OFF_RX_CFG);
  assign selTxCtl  = (paddr == `TXCF_OFF_TX_CTL);
  assign selHwSet  = (paddr == `TXCF_OFF_HW_SET);
  assign selIntSts = (paddr == `TXCF_OFF_INT_STS);
  assign selIntMsk = (paddr == `TXCF_OFF_INT_MSK);
  assign mapped    = selRxCfg || selTxCtl || selHwSet || selIntSts || selIntMsk;

  // stored configuration
  txcf_pkg::txcf_align_t     rxAlign;
  txcf_pkg::txcf_align_t     next_rxAlign;
  logic                      allowOverrun;
  logic                      next_allowOverrun;
  logic                      next_mustSetOne;
  logic [3:0]                next_txAllocKb;
  logic [`TXCF_INT_BITS-1:0] intSts;
  logic [`TXCF_INT_BITS-1:0] next_intSts;
  logic [`TXCF_INT_BITS-1:0] intMsk;
  logic [`TXCF_INT_BITS-1:0] next_intMsk;
  logic                      statusFullSeen;
  logic [`TXCF_INT_BITS-1:0] events;

  always_comb begin
    next_rxAlign      = rxAlign;
    next_allowOverrun = allowOverrun;
    next_mustSetOne   = mustSetOne;
    next_txAllocKb    = txAllocKb;
    next_intMsk       = intMsk;
    if (wrEnd && selRxCfg) begin
      next_rxAlign = txcf_pkg::txcf_align_t'(
        pwdata[`TXCF_RX_ALIGN_HI:`TXCF_RX_ALIGN_LO]);
    end
    if (wrEnd && selTxCtl) begin
      next_allowOverrun = pwdata[`TXCF_BIT_ALLOW_OVR];
    end
    if (wrEnd && selHwSet) begin
      next_mustSetOne = pwdata[`TXCF_BIT_MUST_ONE];
      next_txAllocKb  = pwdata[`TXCF_ALLOC_HI:`TXCF_ALLOC_LO];
      if (next_txAllocKb > `TXCF_ALLOC_MAX_KB) begin
        next_txAllocKb = `TXCF_ALLOC_MAX_KB;
      end
    end
    if (wrEnd && selIntMsk) begin
      next_intMsk = pwdata[`TXCF_INT_BITS-1:0];
    end
    // full event is taken from the raw queue flag, not the stall policy
    events = '0;
    events[`TXCF_INT_STS_FULL] = txStatusFull && !statusFullSeen;
    events[`TXCF_INT_TX_HALT]  = ctl.haltPulse;
    next_intSts = intSts;
    if (wrEnd && selIntSts) begin
      next_intSts = intSts & ~pwdata[`TXCF_INT_BITS-1:0];
    end
    // a new event wins over a clear in the same cycle
    next_intSts = next_intSts | events;
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rxAlign        <= txcf_pkg::ALIGN_4;
      allowOverrun   <= 1'b0;
      mustSetOne     <= 1'b0;
      txAllocKb      <= `TXCF_ALLOC_RESET;
      intSts         <= '0;
      intMsk         <= '0;
      statusFullSeen <= 1'b0;
    end else if (clkEn) begin
      rxAlign        <= next_rxAlign;
      allowOverrun   <= next_allowOverrun;
      mustSetOne     <= next_mustSetOne;
      txAllocKb      <= next_txAllocKb;
      intSts         <= next_intSts;
      intMsk         <= next_intMsk;
      statusFullSeen <= txStatusFull;
    end
  end

  // link to the transmit sequencer
  assign ctl.ce           = clkEn;
  assign ctl.onWrite      = wrEnd && selTxCtl;
  assign ctl.onValue      = pwdata[`TXCF_BIT_TX_ON];
  assign ctl.stopWrite    = wrEnd && selTxCtl && pwdata[`TXCF_BIT_STOP];
  assign ctl.allowOverrun = allowOverrun;
  assign ctl.statusFull   = txStatusFull;
  assign ctl.frameActive  = txFrameActive;

  // read data, reserved bits zero
  logic [31:0] rdValue;

  always_comb begin
    rdValue = 32'h0000_0000;
    if (selRxCfg) begin
      rdValue[`TXCF_RX_ALIGN_HI:`TXCF_RX_ALIGN_LO] = rxAlign;
    end
    if (selTxCtl) begin
      rdValue[`TXCF_BIT_ALLOW_OVR] = allowOverrun;
      rdValue[`TXCF_BIT_TX_ON]     = ctl.txOn;
      rdValue[`TXCF_BIT_STOP]      = ctl.stopBusy;
    end
    if (selHwSet) begin
      rdValue[`TXCF_BIT_MUST_ONE]                  = mustSetOne;
      rdValue[`TXCF_ALLOC_HI:`TXCF_ALLOC_LO]       = txAllocKb;
    end
    if (selIntSts) begin
      rdValue[`TXCF_INT_BITS-1:0] = intSts;
    end
    if (selIntMsk) begin
      rdValue[`TXCF_INT_BITS-1:0] = intMsk;
    end
  end

  // bus answer one cycle into the access phase
  logic        next_pready;
  logic        next_pslverr;
  logic [31:0] next_prdata;

  always_comb begin
    next_pready  = psel && penable && !pready;
    next_pslverr = next_pready && !mapped;
    next_prdata  = 32'h0000_0000;
    if (next_pready && !pwrite) begin
      next_prdata = rdValue;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (clkEn) begin
      pready  <= next_pready;
      pslverr <= next_pslverr;
      prdata  <= next_prdata;
    end
  end

  // flushes, partition and engine outputs
  logic        next_txStatusFlush;
  logic        next_txDataFlush;
  logic        next_irq;
  logic [14:0] allocBytes;
  logic [14:0] next_txDataBytes;
  logic [14:0] next_rxBytes;

  always_comb begin
    next_txStatusFlush = wrEnd && selTxCtl && pwdata[`TXCF_BIT_FLUSH_STS];
    next_txDataFlush   = wrEnd && selTxCtl && pwdata[`TXCF_BIT_FLUSH_DAT];
    allocBytes         = 15'({txAllocKb, 10'h000});
    next_txDataBytes   = allocBytes - 15'(`TXCF_STS_BYTES);
    next_rxBytes       = 15'(`TXCF_TOTAL_KB * `TXCF_KB_BYTES) - allocBytes;
    next_irq           = |(intSts & intMsk);
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      txStatusFlush <= 1'b0;
      txDataFlush   <= 1'b0;
      txDataBytes   <= 15'h0000;
      rxBytes       <= 15'h0000;
      irq           <= 1'b0;
      txRun         <= 1'b0;
      txEnabled     <= 1'b0;
    end else if (clkEn) begin
      txStatusFlush <= next_txStatusFlush;
      txDataFlush   <= next_txDataFlush;
      txDataBytes   <= next_txDataBytes;
      rxBytes       <= next_rxBytes;
      irq           <= next_irq;
      txRun         <= ctl.txRun;
      txEnabled     <= ctl.txOn;
    end
  end

  // receive end padding
  logic [3:0] alignDw;
  logic [2:0] wordCnt;
  logic [2:0] next_wordCnt;
  logic [3:0] padLeft;
  logic [3:0] next_padLeft;
  logic [3:0] usedDw;
  logic       next_rxPadding;

  always_comb begin
    case (rxAlign)
      txcf_pkg::ALIGN_4:  alignDw = `TXCF_ALIGN_DW_4;
      txcf_pkg::ALIGN_16: alignDw = `TXCF_ALIGN_DW_16;
      txcf_pkg::ALIGN_32: alignDw = `TXCF_ALIGN_DW_32;
      default:            alignDw = `TXCF_ALIGN_DW_4;
    endcase
    next_wordCnt = wordCnt;
    next_padLeft = padLeft;
    usedDw       = ({1'b0, wordCnt} + 4'h1) & (alignDw - 4'h1);
    if (rxDataRead) begin
      if (padLeft != 4'h0) begin
        next_padLeft = padLeft - 4'h1;
      end else if (rxDataLast) begin
        next_wordCnt = 3'h0;
        next_padLeft = (alignDw - usedDw) & (alignDw - 4'h1);
      end else begin
        next_wordCnt = wordCnt + 3'h1;
      end
    end
    next_rxPadding = (next_padLeft != 4'h0);
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wordCnt   <= 3'h0;
      padLeft   <= 4'h0;
      rxPadding <= 1'b0;
    end else if (clkEn) begin
      wordCnt   <= next_wordCnt;
      padLeft   <= next_padLeft;
      rxPadding <= next_rxPadding;
    end
  end
endmodule // txcf_regs
`default_nettype wire

// ---- include/txcf_defs.svh ----
`ifndef TXCF_DEFS_SVH
`define TXCF_DEFS_SVH

`define TXCF_OFF_RX_CFG     8'h6C
`define TXCF_OFF_TX_CTL     8'h70
`define TXCF_OFF_HW_SET     8'h74
`define TXCF_OFF_INT_STS    8'h80
`define TXCF_OFF_INT_MSK    8'h84

`define TXCF_RX_ALIGN_HI    31
`define TXCF_RX_ALIGN_LO    30
`define TXCF_BIT_FLUSH_STS  15
`define TXCF_BIT_FLUSH_DAT  14
`define TXCF_BIT_ALLOW_OVR  2
`define TXCF_BIT_TX_ON      1
`define TXCF_BIT_STOP       0
`define TXCF_BIT_MUST_ONE   20
`define TXCF_ALLOC_HI       19
`define TXCF_ALLOC_LO       16

`define TXCF_INT_STS_FULL   0
`define TXCF_INT_TX_HALT    1
`define TXCF_INT_BITS       2

`define TXCF_ALLOC_RESET    4'h5
`define TXCF_ALLOC_MAX_KB   4'hE
`define TXCF_TOTAL_KB       16
`define TXCF_KB_BYTES       1024
`define TXCF_STS_BYTES      512

`define TXCF_ALIGN_DW_4     4'h1
`define TXCF_ALIGN_DW_16    4'h4
`define TXCF_ALIGN_DW_32    4'h8

`endif

// ---- include/txcf_pkg.sv ----
`default_nettype none
package txcf_pkg;
  typedef enum logic [1:0] {
    ALIGN_4   = 2'b00,
    ALIGN_16  = 2'b01,
    ALIGN_32  = 2'b10,
    ALIGN_RSV = 2'b11
  } txcf_align_t;

  typedef enum logic [1:0] {
    TX_OFF   = 2'b00,
    TX_RUN   = 2'b01,
    TX_DRAIN = 2'b10
  } txcf_txstate_t;
endpackage
`default_nettype wire

// ---- include/txcf_ctl_if.sv ----
`default_nettype none
interface txcf_ctl_if;
  logic ce;
  logic onWrite;
  logic onValue;
  logic stopWrite;
  logic allowOverrun;
  logic statusFull;
  logic frameActive;
  logic txOn;
  logic stopBusy;
  logic txRun;
  logic haltPulse;

  modport regs (
    output ce, onWrite, onValue, stopWrite, allowOverrun, statusFull, frameActive,
    input  txOn, stopBusy, txRun, haltPulse
  );
  modport seq (
    input  ce, onWrite, onValue, stopWrite, allowOverrun, statusFull, frameActive,
    output txOn, stopBusy, txRun, haltPulse
  );
endinterface
`default_nettype wire

// ---- src/txcf_tx_seq.sv ----
`default_nettype none
module txcf_tx_seq (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // control link to the register bank
  txcf_ctl_if.seq   ctl
);
  txcf_pkg::txcf_txstate_t state;
  txcf_pkg::txcf_txstate_t next_state;
  logic                    stopBusy;
  logic                    next_stopBusy;
  logic                    txRun;
  logic                    next_txRun;
  logic                    haltPulse;
  logic                    next_haltPulse;

  always_comb begin
    next_state     = state;
    next_stopBusy  = stopBusy;
    next_haltPulse = 1'b0;
    case (state)
      txcf_pkg::TX_OFF: begin
        if (ctl.onWrite && ctl.onValue) begin
          next_state = txcf_pkg::TX_RUN;
        end
      end
      txcf_pkg::TX_RUN: begin
        if (ctl.onWrite && !ctl.onValue) begin
          next_state = txcf_pkg::TX_OFF;
        end else if (stopBusy) begin
          next_state = txcf_pkg::TX_DRAIN;
        end
      end
      txcf_pkg::TX_DRAIN: begin
        // current frame runs to its end before the halt
        if (!ctl.frameActive) begin
          next_state     = txcf_pkg::TX_OFF;
          next_stopBusy  = 1'b0;
          next_haltPulse = 1'b1;
        end
      end
      default: begin
        next_state = txcf_pkg::TX_OFF;
      end
    endcase
    if (state == txcf_pkg::TX_OFF && stopBusy) begin
      next_stopBusy  = 1'b0;
      next_haltPulse = 1'b1;
    end
    if (ctl.stopWrite && !stopBusy) begin
      next_stopBusy = 1'b1;
    end
    // no new frame while stopping or while a full status queue stalls
    next_txRun = (next_state == txcf_pkg::TX_RUN) && !next_stopBusy
                 && (ctl.allowOverrun || !ctl.statusFull);
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state     <= txcf_pkg::TX_OFF;
      stopBusy  <= 1'b0;
      txRun     <= 1'b0;
      haltPulse <= 1'b0;
    end else if (ctl.ce) begin
      state     <= next_state;
      stopBusy  <= next_stopBusy;
      txRun     <= next_txRun;
      haltPulse <= next_haltPulse;
    end
  end

  assign ctl.txOn      = (state != txcf_pkg::TX_OFF);
  assign ctl.stopBusy  = stopBusy;
  assign ctl.txRun     = txRun;
  assign ctl.haltPulse = haltPulse;
endmodule // txcf_tx_seq
`default_nettype wire

// ---- dv/txcf_regs_sva.sv ----
`default_nettype none
module txcf_regs_sva (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        clkEn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // engine control and partition
  input wire logic        txRun,
  input wire logic        txEnabled,
  input wire logic        txStatusFlush,
  input wire logic        txDataFlush,
  input wire logic [3:0]  txAllocKb,
  input wire logic [14:0] txDataBytes,
  input wire logic [14:0] rxBytes
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  logic ctlWrite;
  assign ctlWrite = psel && penable && pready && pwrite && paddr == 8'h70;

  ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
  ready_time_a: assert property (psel && penable && !pready && clkEn |=> pready)
    else $error("pready late");
  err_only_a: assert property (pslverr |-> pready) else $error("stray pslverr");
  err_map_a: assert property (pready |-> pslverr == !(paddr inside
    {8'h6C, 8'h70, 8'h74, 8'h80, 8'h84})) else $error("pslverr wrong");
  read_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata stray");
  status_flush_a: assert property (ctlWrite && pwdata[15] |=> txStatusFlush ##1 !txStatusFlush)
    else $error("status flush pulse");
  data_flush_a: assert property (ctlWrite && pwdata[14] |=> txDataFlush ##1 !txDataFlush)
    else $error("data flush pulse");
  alloc_max_a: assert property (txAllocKb <= 4'hE) else $error("alloc above max");
  data_split_a: assert property ($stable(txAllocKb) && clkEn ##1 $stable(txAllocKb)
    |-> txDataBytes == {1'b0, txAllocKb, 10'h0} - 15'h0200) else $error("data split");
  rx_split_a: assert property ($stable(txAllocKb) && clkEn ##1 $stable(txAllocKb)
    |-> rxBytes == 15'h4000 - {1'b0, txAllocKb, 10'h0}) else $error("rx split");
  run_gate_a: assert property ($rose(txRun) |-> txEnabled) else $error("run while off");
endmodule // txcf_regs_sva

bind txcf_regs txcf_regs_sva i_sva (.sys_clk, .sys_rst, .clkEn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .txRun, .txEnabled, .txStatusFlush,
  .txDataFlush, .txAllocKb, .txDataBytes, .rxBytes);
`default_nettype wire

// ---- dv/txcf_engine_model.sv ----
`default_nettype none
module txcf_engine_model #(
  parameter int FRAME_LEN = 24,
  parameter int FULL_AT   = 2
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // control from the register bank
  input  wire logic txRun,
  input  wire logic txStatusFlush,
  // engine status
  output logic      txStatusFull,
  output logic      txFrameActive
);
  timeunit 1ns;
  timeprecision 1ps;
  int frameCnt;
  int stsCnt;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      frameCnt <= 0;
      stsCnt <= 0;
      txFrameActive <= 1'b0;
    end else begin
      if (txFrameActive) begin
        frameCnt <= frameCnt + 1;
        // a begun frame always runs to its end
        if (frameCnt == FRAME_LEN - 1) begin
          txFrameActive <= 1'b0;
          stsCnt <= stsCnt + 1;
        end
      end else if (txRun) begin
        txFrameActive <= 1'b1;
        frameCnt <= 0;
      end
      if (txStatusFlush) stsCnt <= 0;
    end
  end
  assign txStatusFull = (stsCnt >= FULL_AT);
endmodule // txcf_engine_model
`default_nettype wire

// ---- dv/tx_config_and_fifo_partition_test.sv ----
`default_nettype none
module tx_config_and_fifo_partition_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        clkEn = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        rxDataRead = 1'b0;
  logic        rxDataLast = 1'b0;
  logic [31:0] prdata, rdVal;
  logic        pready, pslverr, errFlag, txStatusFull, txFrameActive;
  logic        txRun, txEnabled, txStatusFlush, txDataFlush, rxPadding, mustSetOne, irq;
  logic [3:0]  txAllocKb;
  logic [14:0] txDataBytes, rxBytes;
  logic [31:0] padWords [5] = '{32'h0, 32'h3, 32'h7, 32'h0, 32'h3};
  int          errTotal = 0;
  int          cmpCount = 0;

  always #20 sys_clk = ~sys_clk;

  txcf_regs i_dut (.sys_clk, .sys_rst, .clkEn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .txStatusFull, .txFrameActive, .rxDataRead, .rxDataLast,
    .txRun, .txEnabled, .txStatusFlush, .txDataFlush, .rxPadding, .txAllocKb,
    .txDataBytes, .rxBytes, .mustSetOne, .irq);
  txcf_engine_model i_eng (.sys_clk, .sys_rst, .txRun, .txStatusFlush, .txStatusFull,
    .txFrameActive);

  task automatic endSim();
    if (errTotal == 0 && cmpCount > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp) begin
      errTotal++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rdVal = prdata;
    errFlag = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    check(rdVal, exp);
  endtask

  task automatic tPartition();
    rd(8'h70, 32'h0);
    rd(8'h74, 32'h0005_0000);
    check(32'(txDataBytes), 32'h1200);
    check(32'(rxBytes), 32'h2C00);
    // transmitter and receiver idle here
    wr(8'h74, 32'hFFFF_FFFF);
    rd(8'h74, 32'h001E_0000);
    check(32'(mustSetOne), 32'h1);
    cyc(3);
    check(32'(txDataBytes), 32'h3600);
    check(32'(rxBytes), 32'h0800);
    wr(8'h74, 32'h0012_0000);
    cyc(3);
    check(32'(txDataBytes), 32'h0600);
    check(32'(rxBytes), 32'h3800);
    wr(8'h3C, 32'h1);
    check(32'(errFlag), 32'h1);
    rd(8'h3C, 32'h0);
    wr(8'h74, 32'h0015_0000);
  endtask

  task automatic tAlign();
    int n;
    logic [1:0] code;
    // last pass repeats 16-byte alignment with reads while the enable is low
    for (int c = 0; c < 5; c++) begin
      code = c[1:0] | {1'b0, c[2]};
      wr(8'h6C, {code, 30'h0});
      rd(8'h6C, {code, 30'h0});
      rxDataRead <= 1'b1;
      rxDataLast <= 1'b1;
      @(posedge sys_clk);
      rxDataRead <= (c == 4);
      rxDataLast <= 1'b0;
      clkEn <= (c != 4);
      cyc(2);
      rxDataRead <= 1'b0;
      clkEn <= 1'b1;
      cyc(1);
      n = 0;
      while (rxPadding === 1'b1 && n < 10) begin
        rxDataRead <= 1'b1;
        @(posedge sys_clk);
        rxDataRead <= 1'b0;
        cyc(2);
        n++;
      end
      check(32'(n), padWords[c]);
    end
  endtask

  task automatic tOverrun();
    wr(8'h70, 32'h0000_C000);
    rd(8'h70, 32'h0);
    wr(8'h84, 32'h3);
    wr(8'h70, 32'h2);
    while (txStatusFull !== 1'b1) @(posedge sys_clk);
    cyc(4);
    check(32'(txRun), 32'h0);
    rd(8'h80, 32'h1);
    check(32'(irq), 32'h1);
    wr(8'h80, 32'h1);
    rd(8'h80, 32'h0);
    wr(8'h70, 32'h6);
    cyc(4);
    check(32'(txRun), 32'h1);
    wr(8'h70, 32'h0000_8006);
    // let the flush take the full flag down before waiting for it again
    while (txStatusFull === 1'b1) @(posedge sys_clk);
    while (txStatusFull !== 1'b1) @(posedge sys_clk);
    cyc(2);
    rd(8'h80, 32'h1);
    wr(8'h80, 32'h1);
  endtask

  task automatic tStop();
    wr(8'h84, 32'h2);
    while (txFrameActive === 1'b1) @(posedge sys_clk);
    while (txFrameActive !== 1'b1) @(posedge sys_clk);
    wr(8'h70, 32'h7);
    rd(8'h70, 32'h7);
    wr(8'h70, 32'h6);
    rd(8'h70, 32'h7);
    check(32'(txFrameActive), 32'h1);
    while (txEnabled === 1'b1) @(posedge sys_clk);
    check(32'(txFrameActive), 32'h0);
    rd(8'h70, 32'h4);
    check(32'(irq), 32'h1);
    wr(8'h80, 32'h2);
    cyc(2);
    check(32'(irq), 32'h0);
    // stop asked while already off clears at once and still reports a halt
    wr(8'h70, 32'h1);
    rd(8'h70, 32'h0);
    check(32'(irq), 32'h1);
  endtask

  initial begin
    cyc(10);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    tPartition();
    tAlign();
    tOverrun();
    tStop();
    endSim();
  end

  initial begin
    #800000;
    errTotal++;
    endSim();
  end
endmodule // tx_config_and_fifo_partition_test
`default_nettype wire
